//--- src/smb_slave.sv
`timescale 1ns/1ps
module smb_slave #(
    parameter logic [6:0]  DEV_ADDR = smb_pkg::DEV_ADDR_DEF,
    parameter logic [32:0] WDT_CYC  = smb_pkg::WDT_CYC_DEF
) (
    // Link side
    input  wire logic        link_clk_i,
    smb_if.dev               bus,
    // System side
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        wdt_en_i,
    output logic      [7:0]  reg_addr_o,
    output logic             wr_stb_o,
    output logic      [15:0] wr_data_o,
    output logic             charge_stop_o
);
    import smb_pkg::*;

    typedef struct packed {
        logic        scl_m;
        logic        scl_s;
        logic        scl_p;
        logic        sda_m;
        logic        sda_s;
        logic        sda_p;
        logic        ack_m;
        logic        ack_s;
        logic        ack_p;
        logic        rdy;
        link_st_t    st;
        logic [3:0]  cnt;
        logic [2:0]  idx;
        logic        rw;
        logic        more;
        logic        hi_sent;
        logic [7:0]  sr;
        logic [7:0]  tx;
        logic [7:0]  reg_a;
        logic [7:0]  wlo;
        logic [7:0]  whi;
        logic [15:0] rd_word;
        logic        oe;
        logic        req_t;
        logic        kind;
    } link_t;

    typedef struct packed {
        logic        req_m;
        logic        req_s;
        logic        req_p;
        logic        stage;
        logic        ack_t;
        logic [7:0]  reg_a;
        logic [15:0] wdata;
        logic        wr_stb;
        logic [15:0] rword;
        logic [32:0] wdt;
        logic        stop;
    } sys_t;

    link_t l_q;
    link_t l_d;
    sys_t  s_q;
    sys_t  s_d;
    logic  rise;
    logic  fall;
    logic  start;
    logic  stop;

    // Link domain: scl and sda only seen through two flops
    always_comb begin
        l_d       = l_q;
        l_d.scl_m = bus.scl;
        l_d.scl_s = l_q.scl_m;
        l_d.scl_p = l_q.scl_s;
        l_d.sda_m = bus.sda;
        l_d.sda_s = l_q.sda_m;
        l_d.sda_p = l_q.sda_s;
        l_d.ack_m = s_q.ack_t;
        l_d.ack_s = l_q.ack_m;
        l_d.ack_p = l_q.ack_s;
        l_d.rdy   = 1'h1;
        // Word is stable in the system domain once ack toggles
        if (l_q.ack_s != l_q.ack_p) begin
            l_d.rd_word = s_q.rword;
        end
        rise  = l_q.scl_s & ~l_q.scl_p;
        fall  = ~l_q.scl_s & l_q.scl_p;
        start = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
        stop  = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;
        if (start) begin
            l_d.st  = L_RX;
            l_d.cnt = 4'h0;
            l_d.idx = IDX_CTRL;
            l_d.rw  = DIR_WRITE;
            l_d.oe  = 1'h0;
        end else if (stop) begin
            l_d.st = L_IDLE;
            l_d.oe = 1'h0;
        end else begin
            case (l_q.st)
                L_RX: begin
                    if (rise) begin
                        l_d.sr  = {l_q.sr[6:0], l_q.sda_s};
                        l_d.cnt = l_q.cnt + 4'h1;
                    end else if (fall && l_q.cnt == BYTE_BITS) begin
                        l_d.st = L_ACK;
                        l_d.oe = 1'h1;
                        case (l_q.idx)
                            IDX_CTRL: begin
                                if (l_q.sr[7:1] == DEV_ADDR && l_q.rdy)
                                begin
                                    l_d.rw = l_q.sr[0];
                                end else begin
                                    l_d.st = L_IDLE;
                                    l_d.oe = 1'h0;
                                end
                            end
                            IDX_REG: begin
                                l_d.reg_a = l_q.sr;
                                l_d.kind  = 1'h0;
                                l_d.req_t = ~l_q.req_t;
                            end
                            IDX_LO: begin
                                l_d.wlo = l_q.sr;
                            end
                            IDX_HI: begin
                                l_d.whi   = l_q.sr;
                                l_d.kind  = 1'h1;
                                l_d.req_t = ~l_q.req_t;
                            end
                            default: begin
                                l_d.st = L_IDLE;
                                l_d.oe = 1'h0;
                            end
                        endcase
                    end
                end
                L_ACK: begin
                    // ninth pulse is the ack slot
                    if (rise) begin
                        l_d.cnt = ACK_SLOT;
                    end else if (fall && l_q.cnt == ACK_SLOT) begin
                        l_d.cnt = 4'h0;
                        l_d.idx = l_q.idx + 3'h1;
                        // release or drive only after fall
                        l_d.oe  = 1'h0;
                        l_d.st  = L_RX;
                        if (l_q.rw == DIR_READ) begin
                            l_d.st      = L_TX;
                            l_d.hi_sent = 1'h0;
                            l_d.tx      = l_q.rd_word[7:0];
                            l_d.oe      = ~l_q.rd_word[7];
                        end
                    end
                end
                L_TX: begin
                    if (rise) begin
                        l_d.cnt = l_q.cnt + 4'h1;
                    end else if (fall) begin
                        if (l_q.cnt == BYTE_BITS) begin
                            l_d.oe = 1'h0;
                            l_d.st = L_RACK;
                        end else begin
                            l_d.tx = {l_q.tx[6:0], 1'h0};
                            l_d.oe = ~l_q.tx[6];
                        end
                    end
                end
                L_RACK: begin
                    if (rise) begin
                        l_d.cnt  = ACK_SLOT;
                        l_d.more = ~l_q.sda_s;
                    end else if (fall && l_q.cnt == ACK_SLOT) begin
                        l_d.cnt = 4'h0;
                        l_d.st  = L_IDLE;
                        if (l_q.more && !l_q.hi_sent) begin
                            l_d.st      = L_TX;
                            l_d.hi_sent = 1'h1;
                            l_d.tx      = l_q.rd_word[15:8];
                            l_d.oe      = ~l_q.rd_word[15];
                        end
                    end
                end
                default: begin
                    l_d.oe = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // System domain: toggle handshake, fields stable while pending
    always_comb begin
        s_d        = s_q;
        s_d.req_m  = l_q.req_t;
        s_d.req_s  = s_q.req_m;
        s_d.req_p  = s_q.req_s;
        s_d.wr_stb = 1'h0;
        if (s_q.req_s != s_q.req_p) begin
            s_d.reg_a = l_q.reg_a;
            s_d.stage = 1'h1;
            if (l_q.kind) begin
                s_d.wdata  = {l_q.whi, l_q.wlo};
                s_d.wr_stb = 1'h1;
            end
        end else if (s_q.stage) begin
            // Read data sampled a cycle after the address settles
            s_d.stage = 1'h0;
            s_d.rword = rd_data_i;
            s_d.ack_t = ~s_q.ack_t;
        end
        if (!wdt_en_i) begin
            s_d.wdt  = '0;
            s_d.stop = 1'h0;
        end else if (s_q.wr_stb && (s_q.reg_a == REG_FAST_CHG ||
                                    s_q.reg_a == REG_SYS_RAIL)) begin
            s_d.wdt  = '0;
            // Expiry in the same cycle as a kick still wins
            s_d.stop = !s_q.stop && s_q.wdt == WDT_CYC - 33'h1;
        end else if (!s_q.stop) begin
            if (s_q.wdt == WDT_CYC - 33'h1) begin
                s_d.stop = 1'h1;
            end else begin
                s_d.wdt = s_q.wdt + 33'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.d_sda_o    = 1'h0;
    assign bus.d_sda_oe   = l_q.oe;
    assign reg_addr_o     = s_q.reg_a;
    assign wr_stb_o       = s_q.wr_stb;
    assign wr_data_o      = s_q.wdata;
    assign charge_stop_o  = s_q.stop;
endmodule : smb_slave

//--- src/smb_pkg.sv
// How it works
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop
// - Nine clock pulses per byte, ninth acknowledges
// - Host sends address and direction first
// - Matching address: device pulls acknowledge low
// - Device answers only its seven-bit address
// - Direction bit: zero writes, one reads
// - Mismatch or not ready: acknowledge stays high
// - Host then sends register address byte
// - Device acknowledges and latches register byte
// - Every byte eight bits plus acknowledge
// - Bits shift most significant first
// - Low byte travels before high byte
// - Registers are sixteen bits wide
// - Port accepts traffic only after reset
// - Only word read and word write
// - Device never starts a transaction
// - Control byte 0x13 reads, 0x12 writes
// - Slave address is a build parameter
// - Watchdog stops charging without fast-charge or rail writes
package smb_pkg;
    localparam logic [6:0]  DEV_ADDR_DEF  = 7'h09;
    localparam logic        DIR_WRITE     = 1'h0;
    localparam logic        DIR_READ      = 1'h1;
    localparam logic [7:0]  CTRL_WR       = 8'h12;
    localparam logic [7:0]  CTRL_RD       = 8'h13;
    localparam logic [7:0]  REG_FAST_CHG  = 8'h14;
    localparam logic [7:0]  REG_SYS_RAIL  = 8'h15;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [3:0]  ACK_SLOT      = 4'h9;
    localparam logic [2:0]  IDX_CTRL      = 3'h0;
    localparam logic [2:0]  IDX_REG       = 3'h1;
    localparam logic [2:0]  IDX_LO        = 3'h2;
    localparam logic [2:0]  IDX_HI        = 3'h3;
    localparam logic [2:0]  STEP_W_STOP   = 3'h5;
    localparam logic [2:0]  STEP_R_LO     = 3'h5;
    localparam logic [2:0]  STEP_R_HI     = 3'h6;
    localparam logic [2:0]  STEP_R_STOP   = 3'h7;
    localparam logic [1:0]  PH_SAMPLE     = 2'h2;
    localparam logic [1:0]  PH_LAST       = 2'h3;
    localparam int          SYS_CLK_NS    = 40;
    localparam longint      SYS_HZ        = 25000000;
    // Start setup is the longest quarter the host needs
    localparam int          T_SU_STA_NS   = 4700;
    localparam int          QTR_CYC       =
        (T_SU_STA_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [7:0]  QTR_LAST      = 8'(QTR_CYC - 1);
    localparam longint      WDT_S         = 175;
    localparam logic [32:0] WDT_CYC_DEF   = 33'(WDT_S * SYS_HZ);

    typedef enum logic [2:0] {
        L_IDLE = 3'h0,
        L_RX   = 3'h1,
        L_ACK  = 3'h2,
        L_TX   = 3'h3,
        L_RACK = 3'h4
    } link_st_t;

    typedef enum logic [1:0] {
        K_START = 2'h0,
        K_WBYTE = 2'h1,
        K_RBYTE = 2'h2,
        K_STOP  = 2'h3
    } sym_t;
endpackage : smb_pkg

//--- src/smb_if.sv
`timescale 1ns/1ps
interface smb_if;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Pull-ups: a line is low only while someone drives a low
    assign scl = ~(h_scl_oe & ~h_scl_o);
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

    modport dev (
        input  scl,
        input  sda,
        output d_sda_o,
        output d_sda_oe
    );
    modport host (
        input  sda,
        output h_scl_o,
        output h_scl_oe,
        output h_sda_o,
        output h_sda_oe
    );
endinterface : smb_if

//--- src/smb_host.sv
`timescale 1ns/1ps
module smb_host (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Bus pins
    smb_if.host              bus,
    // Command
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [7:0]  cmd_reg_i,
    input  wire logic [15:0] cmd_data_i,
    output logic             cmd_ready_o,
    // Response
    output logic             rsp_valid_o,
    output logic             rsp_nack_o,
    output logic      [15:0] rsp_data_o
);
    import smb_pkg::*;

    typedef struct packed {
        logic        run;
        logic        ready;
        logic [7:0]  qcnt;
        logic [1:0]  ph;
        logic [2:0]  step;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        wr;
        logic [7:0]  reg_a;
        logic [15:0] data;
        logic        sda_m;
        logic        sda_s;
        logic        ackbad;
        logic        nack;
        logic        rsp_v;
        logic [15:0] rdat;
        logic        scl_oe;
        logic        sda_oe;
    } host_t;

    host_t q;
    host_t d;
    sym_t  k;
    sym_t  nk;

    // write: S ctrl reg lo hi P
    // read: S ctrl reg Sr ctrl lo hi P
    function automatic sym_t sym_kind(input logic [2:0] s,
                                      input logic wr);
        case (s)
            3'h0:    sym_kind = K_START;
            3'h1:    sym_kind = K_WBYTE;
            3'h2:    sym_kind = K_WBYTE;
            3'h3:    sym_kind = wr ? K_WBYTE : K_START;
            3'h4:    sym_kind = K_WBYTE;
            3'h5:    sym_kind = wr ? K_STOP : K_RBYTE;
            3'h6:    sym_kind = K_RBYTE;
            default: sym_kind = K_STOP;
        endcase
    endfunction : sym_kind

    function automatic logic [7:0] sym_byte(input logic [2:0] s,
                                            input logic wr,
                                            input logic [7:0] ra,
                                            input logic [15:0] dt);
        case (s)
            3'h1:    sym_byte = CTRL_WR;
            3'h2:    sym_byte = ra;
            3'h3:    sym_byte = dt[7:0];
            3'h4:    sym_byte = wr ? dt[15:8] : CTRL_RD;
            default: sym_byte = 8'h00;
        endcase
    endfunction : sym_byte

    always_comb begin
        d       = q;
        d.sda_m = bus.sda;
        d.sda_s = q.sda_m;
        d.rsp_v = 1'h0;
        k       = sym_kind(q.step, q.wr);
        if (!q.run) begin
            d.ready = 1'h1;
            if (cmd_valid_i && q.ready) begin
                d.run   = 1'h1;
                d.ready = 1'h0;
                d.wr    = cmd_write_i;
                d.reg_a = cmd_reg_i;
                d.data  = cmd_data_i;
                d.step  = 3'h0;
                d.ph    = 2'h0;
                d.bitn  = 4'h0;
                d.qcnt  = 8'h00;
                d.nack  = 1'h0;
            end
        end else if (q.qcnt != QTR_LAST) begin
            d.qcnt = q.qcnt + 8'h01;
        end else begin
            d.qcnt = 8'h00;
            d.ph   = q.ph + 2'h1;
            if (q.ph == PH_SAMPLE) begin
                if (q.bitn == BYTE_BITS) begin
                    d.ackbad = q.sda_s;
                end else if (k == K_RBYTE) begin
                    d.sh = {q.sh[6:0], q.sda_s};
                end
            end
            if (q.ph == PH_LAST) begin
                if (k != K_START && k != K_STOP && q.bitn != BYTE_BITS)
                begin
                    d.bitn = q.bitn + 4'h1;
                    if (k == K_WBYTE) begin
                        d.sh = {q.sh[6:0], 1'h0};
                    end
                end else begin
                    d.bitn = 4'h0;
                    d.step = q.step + 3'h1;
                    if (k == K_RBYTE && q.step == STEP_R_LO) begin
                        d.rdat[7:0] = q.sh;
                    end
                    if (k == K_RBYTE && q.step == STEP_R_HI) begin
                        d.rdat[15:8] = q.sh;
                    end
                    if (k == K_WBYTE && q.ackbad) begin
                        d.nack = 1'h1;
                        d.step = q.wr ? STEP_W_STOP : STEP_R_STOP;
                    end
                    if (k == K_STOP) begin
                        d.run   = 1'h0;
                        d.rsp_v = 1'h1;
                    end
                    d.sh = sym_byte(d.step, q.wr, q.reg_a, q.data);
                end
            end
        end
        // Pin levels follow the symbol and its quarter
        nk = sym_kind(d.step, d.wr);
        case (nk)
            // data falls in third quarter, clock high
            K_START: begin
                d.scl_oe = d.ph == 2'h0 || d.ph == PH_LAST;
                d.sda_oe = d.ph[1];
            end
            // data rises in third quarter, clock high
            K_STOP: begin
                d.scl_oe = d.ph == 2'h0;
                d.sda_oe = !d.ph[1];
            end
            // control, register and data bytes driven by host
            K_WBYTE: begin
                d.scl_oe = d.ph == 2'h0 || d.ph == PH_LAST;
                d.sda_oe = d.bitn != BYTE_BITS && !d.sh[7];
            end
            K_RBYTE: begin
                d.scl_oe = d.ph == 2'h0 || d.ph == PH_LAST;
                // ack low byte, leave high byte unacked
                d.sda_oe = d.bitn == BYTE_BITS && d.step == STEP_R_LO;
            end
            default: begin
                d.scl_oe = 1'h0;
                d.sda_oe = 1'h0;
            end
        endcase
        if (!d.run) begin
            d.scl_oe = 1'h0;
            d.sda_oe = 1'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.h_scl_o  = 1'h0;
    assign bus.h_scl_oe = q.scl_oe;
    assign bus.h_sda_o  = 1'h0;
    assign bus.h_sda_oe = q.sda_oe;
    assign cmd_ready_o  = q.ready;
    assign rsp_valid_o  = q.rsp_v;
    assign rsp_nack_o   = q.nack;
    assign rsp_data_o   = q.rdat;
endmodule : smb_host

//--- test/smb_monitor.sv
`timescale 1ns/1ps
module smb_monitor (
    // Clocks and reset
    input wire logic sys_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    input wire logic h_sda_oe,
    input wire logic d_sda_oe
);
    import smb_pkg::*;

    logic       scl_q;
    logic       sda_q;
    logic       fresh_q;
    logic       seg2_q;
    logic [3:0] bit_q;
    logic [2:0] byte_q;
    logic [7:0] sh_q;
    logic       st_ev;
    logic       ack9;

    assign st_ev = scl & scl_q & sda_q & ~sda;
    assign ack9  = bit_q == 4'h9;

    // Bit 10 marks the gap after an acknowledge, so stops never look like one
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q   <= 1'h1;
            sda_q   <= 1'h1;
            fresh_q <= 1'h1;
            seg2_q  <= 1'h0;
            bit_q   <= 4'h0;
            byte_q  <= 3'h0;
            sh_q    <= 8'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl & scl_q & ~sda_q & sda) begin
                fresh_q <= 1'h1;
            end
            if (st_ev) begin
                fresh_q <= 1'h0;
                seg2_q  <= ~fresh_q;
                bit_q   <= 4'h0;
                byte_q  <= 3'h0;
            end else if (scl & ~scl_q) begin
                bit_q  <= (bit_q >= 4'h9) ? 4'h1 : bit_q + 4'h1;
                byte_q <= byte_q + {2'h0, bit_q >= 4'h9};
                if (bit_q != 4'h8) begin
                    sh_q <= {sh_q[6:0], sda};
                end
            end else if (~scl & scl_q & ack9) begin
                bit_q <= 4'ha;
            end
        end
    end

    property p_dev_edge;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        $changed(d_sda_oe) |-> !scl;
    endproperty
    a_dev_edge: assert property (p_dev_edge)
        else $error("device moved sda while scl high");
    property p_ack_held;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        ($rose(scl) && d_sda_oe) |-> d_sda_oe [*8];
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("device let go of sda during scl high");
    property p_ctrl_ack;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (ack9 && byte_q == 3'h0) |-> d_sda_oe;
    endproperty
    a_ctrl_ack: assert property (p_ctrl_ack)
        else $error("own control byte not acknowledged");
    property p_reg_ack;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ($rose(ack9) && byte_q == 3'h1 && !seg2_q) |-> d_sda_oe [*8];
    endproperty
    a_reg_ack: assert property (p_reg_ack)
        else $error("register byte not acknowledged");
    property p_host_rel;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (ack9 && (!seg2_q || byte_q == 3'h0)) |-> !h_sda_oe;
    endproperty
    a_host_rel: assert property (p_host_rel)
        else $error("host held sda in the ninth pulse");
    property p_ctrl_byte;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(ack9) && byte_q == 3'h0 |-> sh_q == (seg2_q ? CTRL_RD : CTRL_WR);
    endproperty
    a_ctrl_byte: assert property (p_ctrl_byte)
        else $error("wrong control byte");
    property p_start_host;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (scl && $past(scl) && $fell(sda)) |-> h_sda_oe && !d_sda_oe;
    endproperty
    a_start_host: assert property (p_start_host)
        else $error("start not made by the host");
    property p_stop_idle;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (scl && $past(scl) && $rose(sda)) |=> !d_sda_oe [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("device drove sda after stop");
endmodule : smb_monitor

//--- test/smbus_word_register_slave_test.sv
`timescale 1ns/1ps
module smbus_word_register_slave_test;
    import smb_pkg::*;
    localparam logic [32:0] WDT_SHORT = 33'hc8;
    logic        sys_clk_i = 1'h0;
    logic        link_clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        cmd_valid_i = 1'h0;
    logic        cmd_write_i = 1'h0;
    logic [7:0]  cmd_reg_i = 8'h0;
    logic [15:0] cmd_data_i = 16'h0;
    logic [15:0] rd_data_i = 16'h0;
    logic        wdt_en_i = 1'h0;
    logic        cmd_ready_o, rsp_valid_o, rsp_nack_o, rsp_nack_b, stb_b;
    logic        wr_stb_o, charge_stop_o, stb_d, stb_d2, stop_at_stb;
    logic [15:0] rsp_data_o, wr_data_o, stb_data;
    logic [7:0]  reg_addr_o, stb_reg;
    int          n_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n_stb_b = 0;
    smb_if bus_a();
    smb_if bus_b();

    smb_slave #(.WDT_CYC(WDT_SHORT)) i_smb_slave (.link_clk_i(link_clk_i),
        .bus(bus_a.dev), .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .rd_data_i(rd_data_i), .wdt_en_i(wdt_en_i), .reg_addr_o(reg_addr_o),
        .wr_stb_o(wr_stb_o), .wr_data_o(wr_data_o),
        .charge_stop_o(charge_stop_o));
    smb_host i_smb_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .bus(bus_a.host), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_reg_i(cmd_reg_i),
        .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_nack_o(rsp_nack_o),
        .rsp_data_o(rsp_data_o));
    // Second pair: slave at another address must stay silent
    smb_slave #(.DEV_ADDR(7'h49), .WDT_CYC(WDT_SHORT)) i_smb_slave_b (
        .link_clk_i(link_clk_i), .bus(bus_b.dev), .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .rd_data_i(rd_data_i), .wdt_en_i(wdt_en_i),
        .reg_addr_o(), .wr_stb_o(stb_b), .wr_data_o(), .charge_stop_o());
    smb_host i_smb_host_b (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .bus(bus_b.host), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_reg_i(cmd_reg_i),
        .cmd_data_i(cmd_data_i), .cmd_ready_o(), .rsp_valid_o(),
        .rsp_nack_o(rsp_nack_b), .rsp_data_o());
    smb_monitor i_smb_monitor (.sys_clk_i(sys_clk_i),
        .link_clk_i(link_clk_i), .rst_n_i(rst_n_i), .scl(bus_a.scl),
        .sda(bus_a.sda), .h_sda_oe(bus_a.h_sda_oe),
        .d_sda_oe(bus_a.d_sda_oe));

    always #20 sys_clk_i = ~sys_clk_i;
    initial begin
        #13;
        forever #32 link_clk_i = ~link_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        stb_d <= wr_stb_o;
        stb_d2 <= stb_d;
        if (wr_stb_o === 1'h1) begin
            stb_reg <= reg_addr_o;
            stb_data <= wr_data_o;
        end
        if (stb_d2 === 1'h1) stop_at_stb <= charge_stop_o;
        if (stb_b === 1'h1) n_stb_b <= n_stb_b + 1;
        if (cyc == 99000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic issue(input logic w, input logic [7:0] r,
                         input logic [15:0] d);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'h1;
        cmd_write_i <= w;
        cmd_reg_i <= r;
        cmd_data_i <= d;
        #1;
        while (cmd_ready_o !== 1'h1) tick();
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'h0;
    endtask : issue

    task automatic run_cmd(input logic w, input logic [7:0] r,
                           input logic [15:0] d);
        issue(w, r, d);
        #1;
        while (rsp_valid_o !== 1'h1) tick();
        chk(16'(rsp_nack_o), 16'h0);
        chk(16'(rsp_nack_b), 16'h1);
    endtask : run_cmd

    task automatic t_write(input logic [7:0] r, input logic [15:0] d,
                           input logic s);
        run_cmd(1'h1, r, d);
        chk({8'h0, stb_reg}, {8'h0, r});
        chk(stb_data, d);
        chk(16'(stop_at_stb), 16'(s));
    endtask : t_write

    task automatic t_read(input logic [7:0] r, input logic [15:0] d);
        @(posedge sys_clk_i);
        rd_data_i <= d;
        run_cmd(1'h0, r, ~d);
        chk(rsp_data_o, d);
        chk({8'h0, reg_addr_o}, {8'h0, r});
    endtask : t_read

    task automatic t_watchdog();
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wdt_en_i <= 1'h1;
        #1;
        while (charge_stop_o !== 1'h1 && n < 400) begin
            tick();
            n++;
        end
        chk(16'(n >= WDT_SHORT - 1 && n <= WDT_SHORT + 2), 16'h1);
        t_write(8'h38, 16'hff00, 1'h1);
        t_write(REG_FAST_CHG, 16'h41a0, 1'h0);
        @(posedge sys_clk_i);
        wdt_en_i <= 1'h0;
        repeat (3) tick();
        chk(16'(charge_stop_o), 16'h0);
    endtask : t_watchdog

    // Reset lands inside the register byte of a write
    task automatic t_reset_mid();
        issue(1'h1, REG_SYS_RAIL, 16'h1234);
        repeat (8000) @(posedge sys_clk_i);
        rst_n_i <= 1'h0;
        repeat (5) tick();
        chk({8'h0, reg_addr_o}, 16'h0);
        @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
    endtask : t_reset_mid

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        repeat (3) @(posedge sys_clk_i);
        t_watchdog();
        t_read(REG_FAST_CHG, 16'h8001);
        t_reset_mid();
        t_read(8'h4d, 16'h7ffe);
        chk(stb_data, 16'h41a0);
        chk(16'(n_stb_b), 16'h0);
        finish_test();
    end
endmodule : smbus_word_register_slave_test
